// ### fpd_pkg.sv
// Constants and types for the fast-page DRAM module controller.
// Assumes a 200 MHz controller clock; all times are rounded to cycles here.
package fpd_pkg;

  // ****************************************
  // Clock and helpers
  // ****************************************
  localparam int CLK_MHZ = 200;
  localparam int CW      = 16;

  function automatic int cyc_up(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int imax(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  // ****************************************
  // Times as specified
  // ****************************************
  localparam int T_PAUSE_US  = 100;
  localparam int INIT_CYCLES = 8;
  localparam int REF_ROWS    = 512;
  localparam int T_REF_MS    = 8;
  localparam int T_RP_NS     = 70;
  localparam int T_RAS_NS    = 80;
  localparam int T_RASMAX_NS = 10000;
  localparam int T_RCD_NS    = 25;
  localparam int T_RAH_NS    = 12;
  localparam int T_CAC_NS    = 20;
  localparam int T_AA_NS     = 45;
  localparam int T_RAC_NS    = 80;
  localparam int T_RC_NS     = 160;
  localparam int T_CSR_NS    = 10;
  localparam int T_CHR_NS    = 15;
  localparam int T_CWD_NS    = 20;
  localparam int T_RWD_NS    = 80;
  localparam int T_AWD_NS    = 45;
  localparam int T_WP_NS     = 15;
  localparam int T_RWL_NS    = 25;
  localparam int T_CWL_NS    = 15;

  // ****************************************
  // Cycle counts
  // ****************************************
  localparam int PAUSE_CYC = T_PAUSE_US * CLK_MHZ;
  localparam int REFI_CYC  = (T_REF_MS * 1000000 / REF_ROWS) * CLK_MHZ / 1000;
  localparam int RASMAX_CYC = T_RASMAX_NS * CLK_MHZ / 1000;

  localparam int C_RP   = cyc_up(T_RP_NS);
  localparam int C_RAS  = cyc_up(T_RAS_NS);
  localparam int C_RCD  = cyc_up(T_RCD_NS);
  localparam int C_RAH  = cyc_up(T_RAH_NS);
  localparam int C_RC   = cyc_up(T_RC_NS);
  localparam int C_CSR  = cyc_up(T_CSR_NS);
  localparam int C_CHR  = cyc_up(T_CHR_NS);
  localparam int C_WP   = cyc_up(T_WP_NS);
  localparam int C_SAMPLE = imax(imax(C_RCD + cyc_up(T_CAC_NS), C_RAH + cyc_up(T_AA_NS)),
                                 cyc_up(T_RAC_NS)) + 1;
  localparam int C_WE_RMW = imax(imax(C_RCD + cyc_up(T_CWD_NS), cyc_up(T_RWD_NS)),
                                 imax(C_RAH + cyc_up(T_AWD_NS), C_SAMPLE + 1));
  localparam int C_RD_END  = imax(C_RAS, C_SAMPLE);
  localparam int C_WR_END  = imax(C_RAS, C_RCD + cyc_up(T_CWL_NS));
  localparam int C_RMW_END = C_WE_RMW + imax(C_WP, imax(cyc_up(T_RWL_NS), cyc_up(T_CWL_NS)));
  localparam int C_CBR_END = C_CSR + C_RAS;
  localparam int C_PRE     = imax(C_RP, C_RC - C_WR_END);

  // ****************************************
  // Request codes and states
  // ****************************************
  typedef enum logic [1:0] {
    OP_READ  = 2'h0,
    OP_WRITE = 2'h1,
    OP_RMW   = 2'h2
  } fpd_op_t;

  typedef enum logic [2:0] {
    ST_PAUSE = 3'h0,
    ST_IDLE  = 3'h1,
    ST_ACC   = 3'h2,
    ST_CBR   = 3'h3,
    ST_PRE   = 3'h4
  } fpd_state_t;

endpackage

// ### fpd_fifo_if.sv
// Handshake carrier between the controller and its read-data FIFO.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface fpd_fifo_if #(parameter int W = 9);
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] in_data;
  logic         out_valid;
  logic         out_ready;
  logic [W-1:0] out_data;

  modport ctrl (output in_valid, output in_data, input in_ready,
                input out_valid, input out_data, output out_ready);
  modport fifo (input in_valid, input in_data, output in_ready,
                output out_valid, output out_data, input out_ready);
endinterface

// ### fpd_fifo.sv
// Synchronous FIFO with valid/ready on both sides and registered flags.
// Assumes one clock and an active-high asynchronous reset.
`timescale 1ns/10ps
module fpd_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 8
) (
  input  wire logic clk,
  input  wire logic rst,
  fpd_fifo_if.fifo  f
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0]   cnt;
  logic [AW:0]   next_cnt;
  logic          push;
  logic          pop;

  assign push = f.in_valid && f.in_ready;
  assign pop  = f.out_valid && f.out_ready;
  assign f.out_data = mem[rptr];

  always_comb begin
    next_cnt = cnt;
    if (push && !pop) begin
      next_cnt = cnt + 1'b1;
    end else if (pop && !push) begin
      next_cnt = cnt - 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt         <= '0;
      f.in_ready  <= 1'b0;
      f.out_valid <= 1'b0;
    end else begin
      cnt         <= next_cnt;
      f.in_ready  <= next_cnt < (AW+1)'(DEPTH);
      f.out_valid <= next_cnt != '0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      if (push) begin
        wptr <= (wptr == AW'(DEPTH-1)) ? '0 : wptr + 1'b1;
      end
      if (pop) begin
        rptr <= (rptr == AW'(DEPTH-1)) ? '0 : rptr + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr] <= f.in_data;
    end
  end

endmodule

// ### fpd_ctrl.sv
// Host controller for a fast-page 1M x 9 DRAM module: init, refresh, accesses.
// Assumes module pins are registered here and inputs are synchronous to mclk.
`timescale 1ns/10ps

// Notes on behaviour
// - After power-up wait 100 us, then run eight row cycles before use.
// - Refresh all 512 rows every 8 ms; one refresh every interval.
// - Never rely on parity output when write enable falls between windows.
// - Read-modify-write only on parity bit, under its own column strobe.
// - Late write enable held for pulse width; early write meets setup/hold.
// - Read keeps write enable high after row or column strobe rises.
// - Column strobe high for precharge time before row strobe falls.
// - Row strobe low at most 10000 ns, or 100000 ns in page bursts.
// - Random cycles no closer than 160 ns.
module fpd_ctrl #(
  parameter int PAUSE_CYC = fpd_pkg::PAUSE_CYC,
  parameter int REFI_CYC  = fpd_pkg::REFI_CYC,
  parameter int FIFO_W    = 9,
  parameter int FIFO_D    = 8
) (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic [1:0]  req_op,
  input  wire logic [19:0] req_addr,
  input  wire logic [8:0]  req_wdata,
  output logic             rd_valid,
  input  wire logic        rd_ready,
  output logic [8:0]       rd_data,
  output logic             init_done,
  output logic             ras_n,
  output logic             cas_n,
  output logic             parity_column_strobe_n,
  output logic             we_n,
  output logic [9:0]       addr,
  input  wire logic [7:0]  common_data_lines_in,
  output logic [7:0]       common_data_lines_out,
  output logic             common_data_lines_oe,
  output logic             parity_data_in,
  input  wire logic        parity_data_out
);
  localparam int CW = fpd_pkg::CW;

  fpd_fifo_if #(.W(FIFO_W)) rdq ();

  fpd_pkg::fpd_state_t state;
  logic [CW-1:0]       tcnt;
  logic [1:0]          cur_op;
  logic [19:0]         cur_addr;
  logic [8:0]          cur_wdata;
  logic [3:0]          init_left;
  logic [CW-1:0]       ref_cnt;
  logic                ref_due;
  logic                take;
  logic                go_cbr;
  logic [CW-1:0]       acc_end;

  // ****************************************
  // Read-data FIFO
  // ****************************************
  fpd_fifo #(.W(FIFO_W), .DEPTH(FIFO_D)) u_rdq (
    .clk (mclk),
    .rst (sys_rst),
    .f   (rdq)
  );

  assign rdq.out_ready = rd_ready;
  assign rd_valid      = rdq.out_valid;
  assign rd_data       = rdq.out_data;

  assign take   = (state == fpd_pkg::ST_IDLE) && req_valid && req_ready;
  assign go_cbr = (state == fpd_pkg::ST_IDLE) && !take && (init_left != '0 || ref_due);
  assign acc_end = (cur_op == fpd_pkg::OP_WRITE) ? CW'(fpd_pkg::C_WR_END) :
                   (cur_op == fpd_pkg::OP_RMW)   ? CW'(fpd_pkg::C_RMW_END) :
                                                   CW'(fpd_pkg::C_RD_END);

  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= fpd_pkg::ST_PAUSE;
      tcnt  <= '0;
    end else begin
      tcnt <= tcnt + 1'b1;
      case (state)
        fpd_pkg::ST_PAUSE: begin
          if (tcnt == CW'(PAUSE_CYC - 1)) begin
            state <= fpd_pkg::ST_IDLE;
            tcnt  <= '0;
          end
        end
        fpd_pkg::ST_IDLE: begin
          tcnt <= '0;
          if (take) begin
            state <= fpd_pkg::ST_ACC;
          end else if (go_cbr) begin
            state <= fpd_pkg::ST_CBR;
          end
        end
        fpd_pkg::ST_ACC: begin
          if (tcnt == acc_end) begin
            state <= fpd_pkg::ST_PRE;
            tcnt  <= '0;
          end
        end
        fpd_pkg::ST_CBR: begin
          if (tcnt == CW'(fpd_pkg::C_CBR_END)) begin
            state <= fpd_pkg::ST_PRE;
            tcnt  <= '0;
          end
        end
        fpd_pkg::ST_PRE: begin
          if (tcnt == CW'(fpd_pkg::C_PRE - 1)) begin
            state <= fpd_pkg::ST_IDLE;
          end
        end
        default: begin
          state <= fpd_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Request capture and handshake
  // ****************************************
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      req_ready <= 1'b0;
      cur_op    <= fpd_pkg::OP_READ;
      cur_addr  <= '0;
      cur_wdata <= '0;
    end else begin
      req_ready <= (state == fpd_pkg::ST_IDLE) && init_done && !ref_due && !go_cbr
                   && rdq.in_ready && !take;
      if (take) begin
        cur_op    <= (req_op == fpd_pkg::OP_RMW || req_op == fpd_pkg::OP_WRITE) ?
                     req_op : fpd_pkg::OP_READ;
        cur_addr  <= req_addr;
        cur_wdata <= req_wdata;
      end
    end
  end

  // ****************************************
  // Init and refresh bookkeeping
  // ****************************************
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      init_left <= 4'(fpd_pkg::INIT_CYCLES);
      init_done <= 1'b0;
      ref_cnt   <= '0;
      ref_due   <= 1'b0;
    end else begin
      if (go_cbr && init_left != '0) begin
        init_left <= init_left - 1'b1;
      end
      init_done <= (init_left == '0) && (state == fpd_pkg::ST_IDLE || init_done);
      ref_cnt   <= (ref_cnt == CW'(REFI_CYC - 1)) ? '0 : ref_cnt + 1'b1;
      ref_due   <= (ref_cnt == CW'(REFI_CYC - 1)) || (ref_due && !go_cbr);
    end
  end

  // ****************************************
  // Module pins
  // ****************************************
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ras_n                  <= 1'b1;
      cas_n                  <= 1'b1;
      parity_column_strobe_n <= 1'b1;
      we_n                   <= 1'b1;
      addr                   <= '0;
      common_data_lines_out  <= '0;
      common_data_lines_oe   <= 1'b0;
      parity_data_in         <= 1'b0;
    end else begin
      if (take) begin
        ras_n                 <= 1'b0;
        addr                  <= req_addr[19:10];
        we_n                  <= req_op != fpd_pkg::OP_WRITE;
        common_data_lines_out <= req_wdata[7:0];
        common_data_lines_oe  <= req_op == fpd_pkg::OP_WRITE;
        parity_data_in        <= req_wdata[8];
      end else if (go_cbr) begin
        cas_n                  <= 1'b0;
        parity_column_strobe_n <= 1'b0;
      end else if (state == fpd_pkg::ST_ACC) begin
        if (tcnt == CW'(fpd_pkg::C_RAH - 1)) begin
          addr <= cur_addr[9:0];
        end
        if (tcnt == CW'(fpd_pkg::C_RCD - 1)) begin
          cas_n                  <= 1'b0;
          parity_column_strobe_n <= 1'b0;
        end
        if (tcnt == CW'(fpd_pkg::C_SAMPLE)) begin
          cas_n <= 1'b1;
          if (cur_op != fpd_pkg::OP_RMW) begin
            parity_column_strobe_n <= 1'b1;
          end
        end
        if (cur_op == fpd_pkg::OP_RMW && tcnt == CW'(fpd_pkg::C_WE_RMW - 1)) begin
          we_n <= 1'b0;
        end
        if (tcnt == acc_end) begin
          ras_n                  <= 1'b1;
          cas_n                  <= 1'b1;
          parity_column_strobe_n <= 1'b1;
          we_n                   <= 1'b1;
          common_data_lines_oe   <= 1'b0;
        end
      end else if (state == fpd_pkg::ST_CBR) begin
        if (tcnt == CW'(fpd_pkg::C_CSR - 1)) begin
          ras_n <= 1'b0;
        end
        if (tcnt == CW'(fpd_pkg::C_CSR + fpd_pkg::C_CHR)) begin
          cas_n                  <= 1'b1;
          parity_column_strobe_n <= 1'b1;
        end
        if (tcnt == CW'(fpd_pkg::C_CBR_END)) begin
          ras_n <= 1'b1;
        end
      end
    end
  end

  // Read data sampled after every access-time path has elapsed
  always_comb begin
    rdq.in_valid = (state == fpd_pkg::ST_ACC) && (cur_op != fpd_pkg::OP_WRITE)
                   && (tcnt == CW'(fpd_pkg::C_SAMPLE));
    rdq.in_data  = {parity_data_out, common_data_lines_in};
  end

  // ****************************************
  // Checks
  // ****************************************
  logic          ras_q;
  logic [3:0]    nfall;
  logic [CW-1:0] sfall;
  logic [CW-1:0] rlow;
  logic [CW-1:0] since_ref;
  logic          rfall;

  assign rfall = ras_q && !ras_n;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ras_q     <= 1'b1;
      nfall     <= '0;
      sfall     <= '1;
      rlow      <= '0;
      since_ref <= '0;
    end else begin
      ras_q     <= ras_n;
      nfall     <= (rfall && nfall != '1) ? nfall + 1'b1 : nfall;
      sfall     <= rfall ? CW'(1) : ((sfall == '1) ? sfall : sfall + 1'b1);
      rlow      <= ras_n ? '0 : rlow + 1'b1;
      since_ref <= (rfall && !cas_n) ? '0 : since_ref + 1'b1;
    end
  end

  AST_INIT_CYCLES: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(init_done) |-> nfall >= 4'(fpd_pkg::INIT_CYCLES))
    else $error("init finished before eight row cycles");
  AST_REFRESH_GAP: assert property (@(posedge mclk) disable iff (sys_rst)
    init_done |-> since_ref <= CW'(REFI_CYC + fpd_pkg::C_RMW_END + 2 * fpd_pkg::C_PRE + 8))
    else $error("refresh interval exceeded");
  AST_RMW_WE_LATE: assert property (@(posedge mclk) disable iff (sys_rst)
    $fell(we_n) && !parity_column_strobe_n |-> rlow >= CW'(fpd_pkg::C_WE_RMW))
    else $error("late write enable inside undefined window");
  AST_RMW_PARITY: assert property (@(posedge mclk) disable iff (sys_rst)
    $fell(we_n) && !$past(ras_n) |-> cas_n && !parity_column_strobe_n)
    else $error("delayed write while common strobe low");
  AST_WE_PULSE: assert property (@(posedge mclk) disable iff (sys_rst)
    $fell(we_n) && !ras_n |-> !we_n [*3])
    else $error("write pulse too short");
  AST_READ_WE_HOLD: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(ras_n) && $past(we_n) |-> we_n [*2])
    else $error("write enable fell after read");
  AST_CAS_PRECHARGE: assert property (@(posedge mclk) disable iff (sys_rst)
    rfall && cas_n |-> $past(cas_n) && $past(cas_n, 2))
    else $error("column strobe precharge too short");
  AST_RAS_WIDTH: assert property (@(posedge mclk) disable iff (sys_rst)
    rlow <= CW'(fpd_pkg::RASMAX_CYC))
    else $error("row strobe low too long");
  AST_CYCLE_TIME: assert property (@(posedge mclk) disable iff (sys_rst)
    rfall |-> sfall >= CW'(fpd_pkg::C_RC))
    else $error("row cycles too close");
  AST_COL_ADDR: assert property (@(posedge mclk) disable iff (sys_rst)
    $fell(cas_n) && !ras_n |-> addr == cur_addr[9:0])
    else $error("column address wrong at strobe");

  COV_READ: cover property (@(posedge mclk) disable iff (sys_rst)
    rdq.in_valid && cur_op == fpd_pkg::OP_READ);
  COV_WRITE: cover property (@(posedge mclk) disable iff (sys_rst)
    $fell(cas_n) && !we_n);
  COV_RMW: cover property (@(posedge mclk) disable iff (sys_rst)
    $fell(we_n) && !parity_column_strobe_n);
  COV_REFRESH: cover property (@(posedge mclk) disable iff (sys_rst)
    rfall && !cas_n && init_done);

endmodule

// ### fpd_dram_model.sv
// Behavioural model of the 1M x 9 fast-page DRAM module at the controller pins.
// Assumes the controller drives all strobes; times are in ns.
`timescale 1ns/10ps
module fpd_dram_model #(
  parameter real PAUSE_NS = 250.0,
  parameter real ACP_NS   = 45.0
) (
  input  wire logic        rst,
  input  wire logic        ras_n,
  input  wire logic        cas_n,
  input  wire logic        pcas_n,
  input  wire logic        we_n,
  input  wire logic [9:0]  addr,
  input  wire logic [7:0]  dq_w,
  input  wire logic        parity_data_in,
  output logic [7:0]       dq_r,
  output logic             parity_data_out,
  output logic [15:0]      viol,
  output logic [15:0]      refs
);
  // ****************************************
  // Array and timing state
  // ****************************************
  logic [8:0] mem [int];
  logic [8:0] m;
  logic [8:0] pm;
  logic [9:0] row;
  int         n_ras;
  int         ca;
  int         pa;
  realtime    t_rst, t_rasf, t_cash, t_wef, t_adr;

  initial begin
    dq_r   = 8'h55;
    parity_data_out = 1'b0;
    viol   = 16'h0000;
    refs   = 16'h0000;
    n_ras  = 0;
    t_rasf = -1000.0;
    t_cash = 0.0;
  end

  function automatic logic [8:0] rd(input int a);
    return mem.exists(a) ? mem[a] : 9'h000;
  endfunction

  // Latest of the row, column strobe, column address and precharge access paths
  function automatic realtime acc_wait();
    realtime w, r, a, p;
    r = t_rasf + fpd_pkg::T_RAC_NS - $realtime;
    a = t_adr + fpd_pkg::T_AA_NS - $realtime;
    p = t_cash + ACP_NS - $realtime;  // Page access from precharge
    w = fpd_pkg::T_CAC_NS;
    if (r > w) w = r;
    if (a > w) w = a;
    if (p > w) w = p;
    return w;
  endfunction

  always @(addr) t_adr = $realtime;  // Column address arrival

  // ****************************************
  // Row strobe: row latch, refresh, controller checks
  // ****************************************
  always @(negedge rst) begin
    t_rst = $realtime;
    n_ras = 0;
  end
  always @(negedge ras_n) begin
    row = addr;
    if (n_ras == 0 && $realtime - t_rst < PAUSE_NS) viol = viol + 1;
    if (!cas_n) refs = refs + 1;  // Internal counter row, address ignored
    else if (n_ras < 8 || $realtime - t_cash < 10.0) viol = viol + 1;
    if ($realtime - t_rasf < fpd_pkg::T_RC_NS) viol = viol + 1;
    t_rasf = $realtime;
    n_ras  = n_ras + 1;
  end
  always @(posedge ras_n) if ($realtime - t_rasf > fpd_pkg::T_RASMAX_NS) viol = viol + 1;

  // ****************************************
  // Common data bits
  // ****************************************
  always @(negedge cas_n) if (!ras_n) begin
    ca = {row, addr};
    m  = rd(ca);
    if (!we_n) begin
      m[7:0]  = dq_w;  // Early write takes data at strobe fall
      mem[ca] = m;
    end else begin
      #(acc_wait());
      if (!cas_n) dq_r = m[7:0];
    end
  end
  always @(posedge cas_n) begin
    t_cash = $realtime;
    #1 dq_r = ~dq_r;  // Released outputs show no stale data
  end

  // ****************************************
  // Parity bit, own strobe and split pins
  // ****************************************
  always @(negedge pcas_n) if (!ras_n) begin
    pa = {row, addr};
    pm = rd(pa);
    if (!we_n) begin
      pm[8]   = parity_data_in;  // Early write, output stays off
      mem[pa] = pm;
    end else begin
      #(acc_wait());
      if (!pcas_n && we_n) parity_data_out = pm[8];  // Read-write output
    end
  end
  always @(negedge we_n) if (!ras_n && !pcas_n) begin
    t_wef = $realtime;
    if ($realtime - t_rasf < fpd_pkg::T_RWD_NS) viol = viol + 1;
    m       = rd(pa);
    m[8]    = parity_data_in;  // Delayed write takes data at enable fall
    mem[pa] = m;
  end
  always @(posedge we_n) if (!pcas_n && $realtime - t_wef < fpd_pkg::T_WP_NS) viol = viol + 1;
  always @(posedge pcas_n) #1 parity_data_out = ~parity_data_out;
endmodule

// ### fpd_ctrl_tb.sv
// Self-checking bench for the DRAM module controller with a device model.
// Assumes fpd_pkg, fpd_fifo_if, fpd_fifo, fpd_ctrl and fpd_dram_model are compiled first.
`timescale 1ns/10ps
module fpd_ctrl_tb;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic        mclk, sys_rst, req_valid, req_ready, rd_valid, rd_ready, init_done;
  logic        ras_n, cas_n, pcas_n, we_n, oe, parity_data_in, parity_data_out;
  logic [1:0]  req_op;
  logic [19:0] req_addr;
  logic [8:0]  req_wdata, rd_data;
  logic [9:0]  addr;
  logic [7:0]  dq_w, dq_r;
  logic [15:0] viol, refs;
  int          bad_count, tests_run;
  logic [7:0]  dq_bus;

  assign dq_bus = oe ? dq_w : ~dq_w;  // Released data lines read back inverted

  fpd_ctrl #(.PAUSE_CYC(50), .REFI_CYC(200)) fpd_ctrl_inst (
    .mclk(mclk), .sys_rst(sys_rst), .req_valid(req_valid), .req_ready(req_ready),
    .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .rd_data(rd_data), .init_done(init_done), .ras_n(ras_n),
    .cas_n(cas_n), .parity_column_strobe_n(pcas_n), .we_n(we_n), .addr(addr),
    .common_data_lines_in(dq_r), .common_data_lines_out(dq_w), .common_data_lines_oe(oe),
    .parity_data_in(parity_data_in), .parity_data_out(parity_data_out));
  fpd_dram_model #(.PAUSE_NS(250.0)) fpd_dram_model_inst (
    .rst(sys_rst), .ras_n(ras_n), .cas_n(cas_n), .pcas_n(pcas_n), .we_n(we_n),
    .addr(addr), .dq_w(dq_bus), .parity_data_in(parity_data_in), .dq_r(dq_r),
    .parity_data_out(parity_data_out), .viol(viol), .refs(refs));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string nm, input logic [8:0] exp, input logic [8:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic do_req(input logic [1:0] op, input logic [19:0] a, input logic [8:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    req_valid <= 1'b1;
    req_op    <= op;
    req_addr  <= a;
    req_wdata <= d;
    @(negedge mclk);
    while (req_ready !== 1'b1 && n < 2000) begin
      @(negedge mclk);
      n++;
    end
    @(posedge mclk);
    req_valid <= 1'b0;
    if (n >= 2000) check("request taken", 9'h001, 9'h000);
  endtask

  task automatic get_rd(input logic [8:0] exp);
    int n;
    n = 0;
    @(negedge mclk);
    while (rd_valid !== 1'b1 && n < 2000) begin
      @(negedge mclk);
      n++;
    end
    check("read data valid", 9'h001, {8'h00, rd_valid});
    check("read data", exp, rd_data);
    @(posedge mclk);
    rd_ready <= 1'b1;
    @(posedge mclk);
    rd_ready <= 1'b0;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_init();
    int n;
    n = 0;
    check("strobes held high in reset", 9'h00f, {5'h00, ras_n, cas_n, pcas_n, we_n});
    check("ready low in reset", 9'h000, {7'h00, req_ready, init_done});
    @(posedge mclk);
    sys_rst <= 1'b0;
    while (init_done !== 1'b1 && n < 3000) begin
      @(negedge mclk);
      n++;
    end
    check("row cycles before init done", 9'h008, refs[8:0]);
  endtask

  task automatic t_wr_rd();
    do_req(2'h1, 20'h00000, 9'h1a5);
    do_req(2'h1, 20'hfffff, 9'h05a);
    do_req(2'h0, 20'h00000, 9'h000);
    get_rd(9'h1a5);
    do_req(2'h0, 20'hfffff, 9'h000);
    get_rd(9'h05a);
  endtask

  task automatic t_rmw();
    do_req(2'h1, 20'h5a3c1, 9'h0c3);
    do_req(2'h2, 20'h5a3c1, 9'h13c);
    get_rd(9'h0c3);  // Old data returned
    do_req(2'h3, 20'h5a3c1, 9'h000);
    get_rd(9'h1c3);  // Only parity rewritten
  endtask

  task automatic t_fifo();
    int n;
    n = 0;
    for (int i = 0; i < 9; i++) do_req(2'h1, 20'h10000 + i, 9'h100 + i * 7);
    for (int i = 0; i < 8; i++) do_req(2'h0, 20'h10000 + i, 9'h000);
    @(posedge mclk);
    req_valid <= 1'b1;
    req_op    <= 2'h0;
    req_addr  <= 20'h10008;
    repeat (60) begin
      @(negedge mclk);
      if (req_ready !== 1'b0) n++;
    end
    check("ready while buffer full", 9'h000, n[8:0]);
    get_rd(9'h100);
    n = 0;
    @(negedge mclk);
    while (req_ready !== 1'b1 && n < 200) begin
      @(negedge mclk);
      n++;
    end
    @(posedge mclk);
    req_valid <= 1'b0;
    check("stalled request taken after pop", 9'h001, {8'h00, n < 200});
    for (int i = 1; i < 9; i++) get_rd(9'h100 + i * 7);
    repeat (40) @(posedge mclk);
    check("buffer empty", 9'h000, {8'h00, rd_valid});
  endtask

  task automatic t_refresh();
    logic [15:0] r0;
    r0 = refs;
    repeat (700) @(posedge mclk);
    check("refreshes in idle span", 9'h001, {8'h00, (refs - r0) >= 16'h0003});
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    bad_count = 0;
    tests_run = 0;
    sys_rst   = 1'b1;
    req_valid = 1'b0;
    rd_ready  = 1'b0;
    req_op    = 2'h0;
    req_addr  = 20'h00000;
    req_wdata = 9'h000;
    repeat (20) @(posedge mclk);
    t_init();
    t_wr_rd();
    t_rmw();
    t_fifo();
    t_refresh();
    check("device timing violations", 9'h000, viol[8:0]);
    end_sim();
  end

  initial begin
    #150000;
    bad_count++;
    end_sim();
  end
endmodule
